// ===== civ_pkg.sv
// package: constants and types for the cpu io space and vectoring block
package civ_pkg;
   localparam int NSRC = 35;
   localparam int CLK_NS = 20;
   localparam int TOUT_NS = 3000;
   localparam int TOUT_CYC = (TOUT_NS + CLK_NS - 1) / CLK_NS;
   localparam int ENTRY_CYC = 4;
   localparam int SP_STEP = 2;
   // apb byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_EN_LO = 8'h04;
   localparam logic [7:0] A_EN_HI = 8'h08;
   localparam logic [7:0] A_FL_LO = 8'h0C;
   localparam logic [7:0] A_FL_HI = 8'h10;
   localparam logic [7:0] A_VECT = 8'h14;
   localparam logic [7:0] A_SP = 8'h18;
   localparam logic [7:0] A_PC = 8'h1C;
   localparam logic [7:0] A_INSTR = 8'h20;
   localparam logic [7:0] A_DATA = 8'h24;
   // control fields
   localparam int C_GIE = 0;
   localparam int C_SMALL = 1;
   localparam int C_RET = 2;
   localparam int C_BUSY = 3;
   localparam int D_WR = 16;
   localparam int R_BUSY = 8;
   localparam logic [7:0] SP_RST = 8'h0F;
   // io instruction word: opcode, register, io address
   localparam int OP_POS = 11;
   localparam int RS_POS = 6;
   localparam logic [4:0] OP_IN = 5'h16;
   localparam logic [4:0] OP_OUT = 5'h17;
   localparam logic [4:0] OP_BSET = 5'h13;
   localparam logic [4:0] OP_BCLR = 5'h11;
   // address spaces
   localparam logic [6:0] IO_BASE = 7'h20;
   localparam logic [6:0] IO_TOP = 7'h5F;
   localparam logic [5:0] BIT_TOP = 6'h1F;
   localparam logic [5:0] FL_IO_TOP = 6'h04;
   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [NSRC-1:0] LARGE_ONLY = 35'h3_C780_0000;

   typedef enum logic [1:0] {C_HOLD = 2'b00, C_TOUT = 2'b01, C_RUN = 2'b11, C_PUSH = 2'b10} civ_cpu_e;
   typedef enum logic [1:0] {IO_IDLE = 2'b00, IO_RD = 2'b01, IO_WR = 2'b11} civ_io_e;

   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] data;
   } civ_io_s;

   // lowest bit is highest priority
   typedef struct packed {
      logic two_wire_irq;
      logic fabric_irq_15, fabric_irq_14, fabric_irq_13, fabric_irq_12;
      logic serial1_tx_done_irq, serial1_tx_empty_irq, serial1_rx_done_irq;
      logic fabric_irq_11, fabric_irq_10, fabric_irq_9, fabric_irq_8;
      logic serial0_tx_done_irq, serial0_tx_empty_irq, serial0_rx_done_irq;
      logic fabric_irq_7, fabric_irq_6, fabric_irq_5, fabric_irq_4;
      logic tmr0_overflow_irq, tmr0_compare_irq, tmr1_overflow_irq;
      logic tmr1_compare_b_irq, tmr1_compare_a_irq, tmr1_capture_irq;
      logic tmr2_overflow_irq, tmr2_compare_irq;
      logic pin_irq_3, fabric_irq_3, pin_irq_2, fabric_irq_2;
      logic pin_irq_1, fabric_irq_1, pin_irq_0, fabric_irq_0;
   } civ_irq_s;
endpackage

// ===== civ_top.sv
// cpu io space decode, interrupt flags, priority and vectoring
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - io word: 5b opcode, 5b register, 6b address
// - registers at $00-$1F, io at $20-$5F
// - io address $00-$3F maps to data $20-$5F
// - other accesses reach io through data window
// - writing one clears flag, zero leaves it
// - bit ops read-modify-write the whole register
// - bit ops only for io $00-$1F
// - cpu samples fabric read data on edge
// - contention after read edge is harmless
// - 35 sources, each masked, plus unmasked reset
// - take only with own and global enable
// - lower vector address means higher priority
// - reset at $0000, vectors two words apart
// - $0002-$0010 alternate fabric and pin irqs
// - $0012-$0020 serve the eight timer irqs
// - $0022-$0028 serve fabric irqs 4-7
// - $002A-$002E serve first serial port
// - fabric 8-15 absent on small part
// - $0038-$003C serve second serial port
// - pin low holds reset, then time-out
// - entry clears global enable, return sets it
// - vectoring clears the causing flag
// - masked flags stay pending until serviced
// - vector five cycles after entry, push pc, sp-2
module civ_top
   import civ_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire civ_irq_s    irq_src,
   input  wire logic        cpu_reset_pin_n,
   output civ_io_s          fabric_io,
   output logic             fabric_io_wr_strobe,
   output logic             fabric_io_read_strobe,
   input  wire logic [7:0]  fabric_io_rdata,
   output logic             cpu_run,
   output logic             vec_valid,
   output logic      [15:0] vec_addr
);
   function automatic logic [5:0] prio_f(input logic [NSRC-1:0] p);
      prio_f = 6'd0;
      for (int i = NSRC - 1; i >= 0; i--)
         if (p[i])
            prio_f = 6'(i);
   endfunction

   function automatic logic [15:0] vec_f(input logic [5:0] i);
      vec_f = {9'd0, 6'(i + 6'd1), 1'b0};
   endfunction

   function automatic logic [39:0] lane_f(input logic [7:0] b, input logic [5:0] a);
      lane_f = 40'({32'd0, b} << {a[2:0], 3'b000});
   endfunction

   function automatic logic mapped_f(input logic [7:0] a);
      mapped_f = (a[1:0] == 2'b00) && (a <= A_DATA);
   endfunction

   logic [NSRC-1:0] src, flag_q, en_q, pend, clr_apb, clr_io, clr_vec;
   logic            gie_q, small_q, rs1_q, rs2_q, entry_go, ret_go, apb_wr;
   logic [7:0]      sp_q, tout_q, io_data_q, res_q, rv;
   logic [31:0]     prdata_q;
   logic [7:0]      stk [0:15];
   logic [7:0]      gpr [0:31];
   logic [15:0]     pc_q, vec_addr_q;
   logic [2:0]      ent_q, io_bit_q;
   logic [5:0]      sel_q, io_addr_q;
   logic [4:0]      io_dst_q;
   logic            io_rmw_q, io_setv_q, io_in_q, vec_valid_q, fl_int;
   civ_cpu_e        cpu_st_q;
   civ_io_e         io_st_q;
   logic            go_rd, go_wr, g_rmw, g_setv, g_in, d_gw, d_gr;
   logic [5:0]      g_addr;
   logic [7:0]      g_data;
   logic [4:0]      g_dst;
   logic [2:0]      g_bit;
   logic [6:0]      d_a;

   assign src = irq_src;
   assign apb_wr = psel && penable && pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped_f(paddr);
   assign prdata = prdata_q;
   assign cpu_run = (cpu_st_q == C_RUN) || (cpu_st_q == C_PUSH);
   assign vec_valid = vec_valid_q;
   assign vec_addr = vec_addr_q;

   // pin passes two flops before use
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
      end
      else
      begin
         rs1_q <= cpu_reset_pin_n;
         rs2_q <= rs1_q;
      end

   // flags pend while masked; set beats any clear
   assign pend = flag_q & en_q & ~(small_q ? LARGE_ONLY : '0);
   assign entry_go = (cpu_st_q == C_RUN) && rs2_q && gie_q && (|pend);
   assign ret_go = apb_wr && (paddr == A_CTRL) && pwdata[C_RET] && (cpu_st_q == C_RUN) && !entry_go;
   assign clr_apb = !apb_wr ? '0 : (paddr == A_FL_LO) ? NSRC'(pwdata) :
                    (paddr == A_FL_HI) ? {pwdata[2:0], 32'd0} : '0;
   assign fl_int = io_addr_q <= FL_IO_TOP;
   assign clr_io = (io_st_q == IO_WR && fl_int) ? NSRC'(lane_f(io_data_q, io_addr_q)) : '0;
   assign clr_vec = (cpu_st_q == C_PUSH && ent_q == 3'(ENTRY_CYC - 1)) ? NSRC'(1) << sel_q : '0;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         flag_q <= '0;
      else
         flag_q <= (flag_q & ~(clr_apb | clr_io | clr_vec)) | src;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         en_q <= '0;
         small_q <= 1'b0;
      end
      else if (apb_wr)
      begin
         if (paddr == A_EN_LO)
            en_q[31:0] <= pwdata;
         else if (paddr == A_EN_HI)
            en_q[NSRC-1:32] <= pwdata[2:0];
         else if (paddr == A_CTRL)
            small_q <= pwdata[C_SMALL];
      end

   // global enable: entry clears, return sets
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         gie_q <= 1'b0;
      else if (!rs2_q || entry_go)
         gie_q <= 1'b0;
      else if (ret_go)
         gie_q <= 1'b1;
      else if (apb_wr && paddr == A_CTRL)
         gie_q <= pwdata[C_GIE];

   // reset hold, time-out, entry sequence
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cpu_st_q <= C_HOLD;
         tout_q <= 8'd0;
         ent_q <= 3'd0;
         sel_q <= 6'd0;
         vec_valid_q <= 1'b0;
         vec_addr_q <= VEC_RESET;
      end
      else
      begin
         vec_valid_q <= 1'b0;
         if (!rs2_q)
         begin
            cpu_st_q <= C_HOLD;
            tout_q <= 8'd0;
         end
         else
            case (cpu_st_q)
               C_HOLD: cpu_st_q <= C_TOUT;
               C_TOUT:
                  if (tout_q == 8'(TOUT_CYC - 1))
                  begin
                     cpu_st_q <= C_RUN;
                     vec_valid_q <= 1'b1;
                     vec_addr_q <= VEC_RESET;
                  end
                  else
                     tout_q <= tout_q + 8'd1;
               C_RUN:
                  if (entry_go)
                  begin
                     cpu_st_q <= C_PUSH;
                     ent_q <= 3'd0;
                     sel_q <= prio_f(pend);
                  end
               C_PUSH:
                  if (ent_q == 3'(ENTRY_CYC - 1))
                  begin
                     cpu_st_q <= C_RUN;
                     vec_valid_q <= 1'b1;
                     // source order is the vector table order
                     vec_addr_q <= vec_f(sel_q);
                  end
                  else
                     ent_q <= ent_q + 3'd1;
               default: cpu_st_q <= C_HOLD;
            endcase
      end

   // pc push and pop on a 16 byte stack
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         sp_q <= SP_RST;
         pc_q <= VEC_RESET;
         for (int i = 0; i < 16; i++)
            stk[i] <= 8'd0;
      end
      else if (entry_go)
      begin
         stk[sp_q[3:0]] <= pc_q[7:0];
         stk[4'(sp_q[3:0] - 4'd1)] <= pc_q[15:8];
         sp_q <= sp_q - 8'(SP_STEP);
      end
      else if (ret_go)
      begin
         pc_q <= {stk[4'(sp_q[3:0] + 4'd1)], stk[4'(sp_q[3:0] + 4'd2)]};
         sp_q <= sp_q + 8'(SP_STEP);
      end
      else if (vec_valid_q)
         pc_q <= vec_addr_q;
      else if (apb_wr && paddr == A_SP)
         sp_q <= pwdata[7:0];
      else if (apb_wr && paddr == A_PC)
         pc_q <= pwdata[15:0];

   // decode of io instruction and data space access
   always_comb
   begin
      go_rd = 1'b0;
      go_wr = 1'b0;
      g_rmw = 1'b0;
      g_setv = 1'b0;
      g_in = 1'b0;
      d_gw = 1'b0;
      d_gr = 1'b0;
      g_addr = pwdata[5:0];
      g_dst = pwdata[RS_POS+:5];
      g_bit = pwdata[RS_POS+:3];
      g_data = gpr[pwdata[RS_POS+:5]];
      d_a = pwdata[6:0];
      if (apb_wr && io_st_q == IO_IDLE && paddr == A_INSTR)
      begin
         if (pwdata[OP_POS+:5] == OP_IN)
         begin
            go_rd = 1'b1;
            g_in = 1'b1;
         end
         else if (pwdata[OP_POS+:5] == OP_OUT)
            go_wr = 1'b1;
         else if ((pwdata[OP_POS+:5] == OP_BSET || pwdata[OP_POS+:5] == OP_BCLR) && g_addr <= BIT_TOP)
         begin
            go_rd = 1'b1;
            g_rmw = 1'b1;
            g_setv = pwdata[OP_POS+:5] == OP_BSET;
         end
      end
      else if (apb_wr && io_st_q == IO_IDLE && paddr == A_DATA)
      begin
         g_addr = 6'(d_a - IO_BASE);
         g_data = pwdata[15:8];
         if (d_a < IO_BASE)
         begin
            d_gw = pwdata[D_WR];
            d_gr = !pwdata[D_WR];
         end
         else if (d_a <= IO_TOP)
         begin
            go_wr = pwdata[D_WR];
            go_rd = !pwdata[D_WR];
         end
      end
   end

   assign rv = fl_int ? 8'({5'd0, flag_q} >> {io_addr_q[2:0], 3'b000}) : fabric_io_rdata;

   // io cycle sequencer: write phase alone, or read phase then optional write back
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         io_st_q <= IO_IDLE;
         io_addr_q <= 6'd0;
         io_data_q <= 8'd0;
         io_rmw_q <= 1'b0;
         io_setv_q <= 1'b0;
         io_in_q <= 1'b0;
         io_dst_q <= 5'd0;
         io_bit_q <= 3'd0;
         res_q <= 8'd0;
      end
      else
         case (io_st_q)
            IO_IDLE:
            begin
               io_addr_q <= g_addr;
               io_data_q <= g_data;
               io_rmw_q <= g_rmw;
               io_setv_q <= g_setv;
               io_in_q <= g_in;
               io_dst_q <= g_dst;
               io_bit_q <= g_bit;
               if (d_gr)
                  res_q <= gpr[d_a[4:0]];
               if (go_rd)
                  io_st_q <= IO_RD;
               else if (go_wr)
                  io_st_q <= IO_WR;
            end
            IO_RD:
            begin
               // data taken at the edge, so late bus overlap is harmless
               res_q <= rv;
               if (io_rmw_q)
               begin
                  io_data_q <= io_setv_q ? rv | (8'd1 << io_bit_q) : rv & ~(8'd1 << io_bit_q);
                  io_st_q <= IO_WR;
               end
               else
                  io_st_q <= IO_IDLE;
            end
            IO_WR: io_st_q <= IO_IDLE;
            default: io_st_q <= IO_IDLE;
         endcase

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         for (int i = 0; i < 32; i++)
            gpr[i] <= 8'd0;
      end
      else if (d_gw)
         gpr[d_a[4:0]] <= g_data;
      else if (io_st_q == IO_RD && io_in_q)
         gpr[io_dst_q] <= rv;

   assign fabric_io = '{addr: io_addr_q, data: io_data_q};
   assign fabric_io_read_strobe = (io_st_q == IO_RD) && !fl_int;
   assign fabric_io_wr_strobe = (io_st_q == IO_WR) && !fl_int;

   // read data registered in the setup phase
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         prdata_q <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         if (paddr == A_CTRL)
            prdata_q <= {28'd0, cpu_st_q == C_PUSH, cpu_run, small_q, gie_q};
         else if (paddr == A_EN_LO)
            prdata_q <= en_q[31:0];
         else if (paddr == A_EN_HI)
            prdata_q <= {29'd0, en_q[NSRC-1:32]};
         else if (paddr == A_FL_LO)
            prdata_q <= flag_q[31:0];
         else if (paddr == A_FL_HI)
            prdata_q <= {29'd0, flag_q[NSRC-1:32]};
         else if (paddr == A_VECT)
            prdata_q <= {16'd0, vec_addr_q};
         else if (paddr == A_SP)
            prdata_q <= {24'd0, sp_q};
         else if (paddr == A_PC)
            prdata_q <= {16'd0, pc_q};
         else if (paddr == A_INSTR || paddr == A_DATA)
            prdata_q <= {23'd0, io_st_q != IO_IDLE, res_q};
         else
            prdata_q <= 32'h0000_0000;
      end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_w1c_flag: assert property (apb_wr && paddr == A_FL_LO && pwdata[0] && !src[0] && io_st_q != IO_WR
      |=> !flag_q[0]) else $error("flag not cleared by write of one");
   a_set_wins: assert property (src[0] |=> flag_q[0]) else $error("flag event lost");
   a_gie_gate: assert property ($rose(cpu_st_q == C_PUSH) |-> $past(gie_q)
      && $past(|(flag_q & en_q))) else $error("entry without enables");
   a_gie_clear: assert property (entry_go |=> !gie_q) else $error("global enable kept on entry");
   a_sp_push: assert property (entry_go |=> sp_q == $past(sp_q) - 8'd2) else $error("stack pointer not moved by 2");
   a_entry_time: assert property (entry_go ##1 rs2_q [*4] |=> vec_valid && vec_addr == vec_f(sel_q)
      ) else $error("vector not issued five cycles after entry");
   a_entry_quiet: assert property (entry_go |=> !vec_valid [*4]) else $error("vector issued too early");
   a_vec_clear: assert property (|clr_vec |=> !flag_q[sel_q] || $past(src[sel_q])) else $error("flag kept");
   a_pin_hold: assert property (!rs2_q |=> !cpu_run && !vec_valid) else $error("cpu ran under reset pin");
   a_tout_wait: assert property ($rose(cpu_run) |-> $past(tout_q) == 8'(TOUT_CYC - 1)
      && vec_valid && vec_addr == VEC_RESET) else $error("run before time-out");
   a_bitop_range: assert property (apb_wr && paddr == A_INSTR && io_st_q == IO_IDLE
      && pwdata[OP_POS+:5] == OP_BSET && pwdata[5] |=> io_st_q == IO_IDLE) else $error("bit op above $1F");
   a_io_map: assert property (fabric_io_read_strobe || fabric_io_wr_strobe |-> fabric_io.addr > FL_IO_TOP
      ) else $error("flag byte sent to fabric");

   c_entry: cover property (entry_go ##5 vec_valid);
   c_return: cover property (ret_go);
   c_rmw: cover property (io_st_q == IO_RD && io_rmw_q ##1 io_st_q == IO_WR);
   c_fabric_rd: cover property (fabric_io_read_strobe);
endmodule
`default_nettype wire

// ===== civ_fabric_model.sv
// fabric side model: io store that answers cpu io reads and writes
`timescale 1ns/10ps
`default_nettype none
module civ_fabric_model
   import civ_pkg::*;
(
   input  wire logic       pclk,
   input  wire civ_io_s    fabric_io,
   input  wire logic       fabric_io_wr_strobe,
   input  wire logic       fabric_io_read_strobe,
   output logic      [7:0] fabric_io_rdata
);
   logic [7:0] mem [64];
   logic [7:0] last_q;

   initial
   begin
      last_q = 8'h00;
      for (int i = 0; i < 64; i++)
         mem[i] = 8'h00;
   end

   always @(posedge pclk)
   begin
      if (fabric_io_wr_strobe)
         mem[fabric_io.addr] <= fabric_io.data;
      if (fabric_io_read_strobe)
         last_q <= mem[fabric_io.addr];
   end

   // outside the read cycle another driver takes the bus: show garbage
   assign fabric_io_rdata = fabric_io_read_strobe ? mem[fabric_io.addr] : ~last_q;
endmodule
`default_nettype wire

// ===== cpu_io_space_and_irq_vectoring_tb.sv
// self-checking bench for io decode and interrupt vectoring
`timescale 1ns/10ps
`default_nettype none
module cpu_io_space_and_irq_vectoring_tb
   import civ_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, cpu_reset_pin_n;
   logic        pready, pslverr, fabric_io_wr_strobe, fabric_io_read_strobe, cpu_run, vec_valid;
   logic [7:0]  paddr, fabric_io_rdata, d, d2;
   logic [31:0] pwdata, prdata;
   logic [15:0] vec_addr;
   civ_irq_s    irq_src;
   civ_io_s     fabric_io;
   logic [32:0] rd_q[$];
   logic [15:0] vec_q[$];
   logic [13:0] fab_q[$];
   logic [5:0]  frd_q[$];
   int          n_mismatch = 0;
   int          samples_checked = 0;

   civ_top civ_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .irq_src, .cpu_reset_pin_n, .fabric_io, .fabric_io_wr_strobe, .fabric_io_read_strobe,
      .fabric_io_rdata, .cpu_run, .vec_valid, .vec_addr);
   civ_fabric_model civ_fabric_model_i (.pclk, .fabric_io, .fabric_io_wr_strobe, .fabric_io_read_strobe,
      .fabric_io_rdata);

   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic report_and_stop();
      // a result that never showed up leaves its note behind
      if (rd_q.size() + vec_q.size() + fab_q.size() + frd_q.size() != 0)
         n_mismatch++;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // an empty queue yields x, so any unexpected result is a mismatch
   always @(posedge pclk)
   begin
      if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0)
         chk({pslverr, prdata}, rd_q.size() ? rd_q.pop_front() : 'x);
      if (vec_valid === 1'b1)
         chk(33'(vec_addr), 33'(vec_q.size() ? vec_q.pop_front() : 16'hxxxx));
      if (fabric_io_wr_strobe === 1'b1)
         chk(33'(fabric_io), 33'(fab_q.size() ? fab_q.pop_front() : 'x));
      if (fabric_io_read_strobe === 1'b1)
         chk(33'(fabric_io.addr), 33'(frd_q.size() ? frd_q.pop_front() : 'x));
   end

   task automatic wr(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         n_mismatch++;
         report_and_stop();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back({a > A_DATA, e});
      wr(1'b0, a, 32'h0000_0000);
   endtask

   task automatic io(input logic [7:0] a, input logic [31:0] w);
      wr(1'b1, a, w);
      repeat (4) @(posedge pclk);
   endtask

   function automatic logic [31:0] dw(input logic w, input logic [7:0] v, input logic [6:0] a);
      return {15'h0000, w, v, 1'b0, a};
   endfunction

   task automatic pulse(input logic [34:0] m);
      @(posedge pclk);
      irq_src <= civ_irq_s'(m);
      @(posedge pclk);
      irq_src <= '0;
   endtask

   task automatic wait_vec(output int c);
      c = 0;
      while (vec_q.size() != 0)
      begin
         @(posedge pclk);
         c++;
         if (c > 400)
         begin
            n_mismatch++;
            report_and_stop();
         end
      end
   endtask

   initial
   begin
      int          c;
      logic [34:0] m;
      presetn = 1'b0;
      cpu_reset_pin_n = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      irq_src = '0;
      c = $urandom(32'h7246f94b);
      repeat (3) @(posedge pclk);
      vec_q.push_back(VEC_RESET);
      presetn <= 1'b1;
      wait_vec(c);
      chk(33'(c >= TOUT_CYC), 33'h1);
      rd(A_CTRL, 32'h0000_0004);
      rd(8'h28, 32'h0000_0000);
      // every source alone: vector, global enable clear on entry, flag cleared, stack step
      for (int i = 0; i < NSRC; i++)
      begin
         m = 35'h1 << i;
         wr(1'b1, A_EN_LO, m[31:0]);
         wr(1'b1, A_EN_HI, {29'h0, m[34:32]});
         wr(1'b1, A_CTRL, 32'h0000_0001);
         vec_q.push_back(16'(2 * (i + 2) - 2));
         pulse(m);
         wait_vec(c);
         chk(33'(c >= ENTRY_CYC), 33'h1);
         rd(A_CTRL, 32'h0000_0004);
         rd(A_SP, 32'h0000_000D);
         rd(A_FL_LO, 32'h0000_0000);
         rd(A_FL_HI, 32'h0000_0000);
         wr(1'b1, A_CTRL, 32'h0000_0004);
         rd(A_CTRL, 32'h0000_0005);
         rd(A_SP, 32'h0000_000F);
         wr(1'b1, A_CTRL, 32'h0000_0000);
      end
      // pending while masked, then served lowest vector first
      wr(1'b1, A_EN_LO, 32'hFFFF_FFFF);
      wr(1'b1, A_EN_HI, 32'h0000_0007);
      pulse(35'h4_0000_0024);
      repeat (10) @(posedge pclk);
      rd(A_FL_LO, 32'h0000_0024);
      rd(A_FL_HI, 32'h0000_0004);
      vec_q.push_back(16'h0006);
      wr(1'b1, A_CTRL, 32'h0000_0001);
      wait_vec(c);
      vec_q.push_back(16'h000C);
      wr(1'b1, A_CTRL, 32'h0000_0004);
      wait_vec(c);
      vec_q.push_back(16'h0046);
      wr(1'b1, A_CTRL, 32'h0000_0004);
      wait_vec(c);
      wr(1'b1, A_CTRL, 32'h0000_0004);
      // small part hides fabric 8
      wr(1'b1, A_CTRL, 32'h0000_0003);
      pulse(35'h0_0080_0000);
      repeat (10) @(posedge pclk);
      rd(A_FL_LO, 32'h0080_0000);
      vec_q.push_back(16'h0030);
      wr(1'b1, A_PC, 32'h0000_1234);
      wr(1'b1, A_CTRL, 32'h0000_0001);
      wait_vec(c);
      rd(A_VECT, 32'h0000_0030);
      rd(A_PC, 32'h0000_0030);
      wr(1'b1, A_CTRL, 32'h0000_0004);
      rd(A_PC, 32'h0000_1234);
      rd(A_SP, 32'h0000_000F);
      wr(1'b1, A_CTRL, 32'h0000_0000);
      // write one clears, zero keeps, bit op clears all set flags
      pulse(35'h0_0000_000B);
      wr(1'b1, A_FL_LO, 32'h0000_0002);
      rd(A_FL_LO, 32'h0000_0009);
      wr(1'b1, A_FL_LO, 32'h0000_0000);
      rd(A_FL_LO, 32'h0000_0009);
      io(A_INSTR, {16'h0000, OP_BSET, 5'd2, 6'h00});
      rd(A_FL_LO, 32'h0000_0000);
      // fabric io through io words and the data window
      d = 8'($urandom());
      d2 = 8'($urandom());
      io(A_DATA, dw(1'b1, d, 7'h05));
      io(A_DATA, dw(1'b0, 8'h00, 7'h05));
      rd(A_DATA, {24'h0, d});
      fab_q.push_back({6'h10, d});
      io(A_INSTR, {16'h0000, OP_OUT, 5'd5, 6'h10});
      frd_q.push_back(6'h10);
      io(A_INSTR, {16'h0000, OP_IN, 5'd6, 6'h10});
      rd(A_INSTR, {24'h0, d});
      fab_q.push_back({6'h11, d2});
      io(A_DATA, dw(1'b1, d2, 7'h31));
      frd_q.push_back(6'h11);
      io(A_DATA, dw(1'b0, 8'h00, 7'h31));
      rd(A_DATA, {24'h0, d2});
      io(A_DATA, dw(1'b1, d2, 7'h60));
      fab_q.push_back({6'h10, d | 8'h08});
      frd_q.push_back(6'h10);
      io(A_INSTR, {16'h0000, OP_BSET, 5'd3, 6'h10});
      fab_q.push_back({6'h10, d & 8'hF7});
      frd_q.push_back(6'h10);
      io(A_INSTR, {16'h0000, OP_BCLR, 5'd3, 6'h10});
      io(A_INSTR, {16'h0000, OP_BSET, 5'd3, 6'h21});
      // pin reset holds the cpu, then the time-out runs again
      wr(1'b1, A_CTRL, 32'h0000_0001);
      @(posedge pclk);
      cpu_reset_pin_n <= 1'b0;
      repeat (5) @(posedge pclk);
      rd(A_CTRL, 32'h0000_0000);
      vec_q.push_back(VEC_RESET);
      cpu_reset_pin_n <= 1'b1;
      wait_vec(c);
      chk(33'(c >= TOUT_CYC), 33'h1);
      rd(A_CTRL, 32'h0000_0004);
      repeat (5) @(posedge pclk);
      report_and_stop();
   end
endmodule
`default_nettype wire
